// *** src/ipf_pkg.sv ***
// constants for the interrupt persistence filter
package ipf_pkg;
  // register map
  localparam logic [7:0] REG_FILTER_SETTING = 8'h43;
  localparam logic [7:0] REG_SYSTEM_CONTROL = 8'h40;
  localparam int SETTING_W = 4;
  localparam int CNT_W = 4;
  localparam logic [3:0] SETTING_RESET = 4'h1;
  localparam logic [3:0] RESERVED_READ = 4'h0;
  localparam int INT_RESET_BIT = 6;
  // persistence setting values and counter constants
  localparam logic [3:0] SET_EVERY_DONE = 4'h0;
  localparam logic [3:0] SET_FOLLOW = 4'h1;
  localparam logic [3:0] SET_PAIR = 4'h2;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;
endpackage : ipf_pkg

// *** src/ipf_run_counter.sv ***
// counter of consecutive differing proximity judgements
module ipf_run_counter (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // judgement strobe
  input wire logic step_i,
  input wire logic judge_i,
  input wire logic status_i,
  input wire logic [3:0] setting_i,
  // result
  output logic change_o
);
  logic [ipf_pkg::CNT_W-1:0] cnt;
  logic last_judge;
  logic [ipf_pkg::CNT_W-1:0] next_cnt;
  logic next_last_judge;
  logic [ipf_pkg::CNT_W-1:0] run_len;

  // run length including current judgement
  always_comb begin
    next_cnt = cnt;
    next_last_judge = last_judge;
    run_len = ipf_pkg::CNT_ONE;
    change_o = 1'b0;
    if (step_i) begin
      next_last_judge = judge_i;
      if (judge_i == status_i) begin
        next_cnt = ipf_pkg::CNT_ZERO;
      end else begin
        if (cnt != ipf_pkg::CNT_ZERO && last_judge == judge_i) begin
          run_len = cnt + ipf_pkg::CNT_ONE;
        end
        if (run_len >= setting_i) begin
          change_o = 1'b1;
          next_cnt = ipf_pkg::CNT_ZERO;
        end else begin
          next_cnt = run_len;
        end
      end
    end
  end

  // state registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cnt <= ipf_pkg::CNT_ZERO;
      last_judge <= 1'b0;
    end else begin
      cnt <= next_cnt;
      last_judge <= next_last_judge;
    end
  end
endmodule : ipf_run_counter

// *** src/ipf_filter.sv ***
// interrupt persistence filter with its setting register
// Overview of operation
// - persistence counting applies to proximity results only, never ambient light.
// - upper four setting bits read zero; lower four hold persistence.
// - setting resets to 0001, re-evaluating after every measurement.
// - setting 0000 activates interrupt on every completed measurement.
// - setting 0001 follows latest judgement after each measurement.
// - setting 0010 needs two agreeing judgements differing from status.
// - settings 3..15 need N identical consecutive judgements differing from status.
// - host writing interrupt-reset bit returns interrupt inactive.
module ipf_filter (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // measurement results
  input wire logic prox_done_i,
  input wire logic prox_judge_i,
  input wire logic light_done_i,
  input wire logic light_judge_i,
  // interrupt status
  output logic irq_active_o
);
  logic [3:0] setting;
  logic irq_active;
  logic [7:0] rdata;
  logic [3:0] next_setting;
  logic next_irq_active;
  logic [7:0] next_rdata;
  logic run_change;
  logic int_reset;

  assign int_reset = reg_wr_i && reg_addr_i == ipf_pkg::REG_SYSTEM_CONTROL &&
                     reg_wdata_i[ipf_pkg::INT_RESET_BIT];

  // only proximity strobes step the counter
  ipf_run_counter u_run (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .step_i(prox_done_i && setting > ipf_pkg::SET_FOLLOW),
    .judge_i(prox_judge_i),
    .status_i(irq_active),
    .setting_i(setting),
    .change_o(run_change)
  );

  // setting register and readback
  always_comb begin
    next_setting = setting;
    if (reg_wr_i && reg_addr_i == ipf_pkg::REG_FILTER_SETTING) begin
      next_setting = reg_wdata_i[ipf_pkg::SETTING_W-1:0];
    end
    next_rdata = 8'h00;
    if (reg_addr_i == ipf_pkg::REG_FILTER_SETTING) begin
      next_rdata = {ipf_pkg::RESERVED_READ, next_setting};
    end
  end

  // interrupt status decision
  always_comb begin
    next_irq_active = irq_active;
    if (setting == ipf_pkg::SET_EVERY_DONE) begin
      if (prox_done_i || light_done_i) begin
        next_irq_active = 1'b1;
      end
    end else if (setting == ipf_pkg::SET_FOLLOW) begin
      if (prox_done_i) begin
        next_irq_active = prox_judge_i;
      end else if (light_done_i) begin
        next_irq_active = light_judge_i;
      end
    end else begin
      if (light_done_i) begin
        next_irq_active = light_judge_i;
      end
      if (run_change) begin
        next_irq_active = ~irq_active;
      end
    end
    if (int_reset) begin
      next_irq_active = 1'b0;
    end
  end

  // registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      setting <= ipf_pkg::SETTING_RESET;
      irq_active <= 1'b0;
      rdata <= 8'h00;
    end else begin
      setting <= next_setting;
      irq_active <= next_irq_active;
      rdata <= next_rdata;
    end
  end

  assign reg_rdata_o = rdata;
  assign irq_active_o = irq_active;

  reserved_zero_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    reg_rdata_o[7:4] == ipf_pkg::RESERVED_READ
  ) else $error("reserved bits nonzero");
  write_mask_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (reg_wr_i && reg_addr_i == ipf_pkg::REG_FILTER_SETTING) |=>
    setting == $past(reg_wdata_i[ipf_pkg::SETTING_W-1:0])
  ) else $error("setting write lost");
  setting_hold_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !(reg_wr_i && reg_addr_i == ipf_pkg::REG_FILTER_SETTING) |=> $stable(setting)
  ) else $error("setting changed without write");
  rdata_setting_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    reg_addr_i == ipf_pkg::REG_FILTER_SETTING |=>
    reg_rdata_o[ipf_pkg::SETTING_W-1:0] == setting
  ) else $error("setting readback wrong");
  rdata_other_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    reg_addr_i != ipf_pkg::REG_FILTER_SETTING |=> reg_rdata_o == '0
  ) else $error("unmapped read nonzero");
  // reset value, checked on the first edge after release
  reset_setting_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $past(rst_i) |-> setting == ipf_pkg::SETTING_RESET
  ) else $error("setting reset wrong");
  reset_outputs_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    $past(rst_i) |-> !irq_active_o && reg_rdata_o == '0
  ) else $error("outputs not idle after reset");
  every_done_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (setting == ipf_pkg::SET_EVERY_DONE && (prox_done_i || light_done_i) && !int_reset)
    |=> irq_active_o
  ) else $error("done did not activate");
  every_hold_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (setting == ipf_pkg::SET_EVERY_DONE && irq_active_o && !int_reset) |=> irq_active_o
  ) else $error("done mode dropped interrupt");
  follow_judge_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (setting == ipf_pkg::SET_FOLLOW && prox_done_i && !int_reset) |=>
    irq_active_o == $past(prox_judge_i)
  ) else $error("follow mode mismatch");
  follow_light_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (setting == ipf_pkg::SET_FOLLOW && light_done_i && !prox_done_i && !int_reset) |=>
    irq_active_o == $past(light_judge_i)
  ) else $error("follow light mismatch");
  int_reset_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    int_reset |=> !irq_active_o
  ) else $error("int reset ignored");
  // first differing judgement of a fresh run
  sequence first_diff_s;
    prox_done_i && prox_judge_i != irq_active_o && u_run.cnt == ipf_pkg::CNT_ZERO;
  endsequence
  no_early_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (setting > ipf_pkg::SET_FOLLOW && !light_done_i && !int_reset) ##0 first_diff_s
    |=> $stable(irq_active_o)
  ) else $error("changed after one judgement");
  // no strobe and no clear between the two judgements
  sequence quiet_s;
    !prox_done_i && !light_done_i && !int_reset;
  endsequence
  // second judgement agreeing with the first, still in pair mode
  sequence agree_s;
    setting == ipf_pkg::SET_PAIR && prox_done_i && prox_judge_i != irq_active_o &&
    !light_done_i && !int_reset;
  endsequence
  pair_change_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (setting == ipf_pkg::SET_PAIR && !light_done_i && !int_reset) ##0 first_diff_s ##1
    quiet_s ##1 agree_s |=> irq_active_o == $past(prox_judge_i)
  ) else $error("pair did not change status");
  run_done_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (run_change && !int_reset) |=> irq_active_o != $past(irq_active_o)
  ) else $error("run did not toggle status");
  change_cause_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (setting > ipf_pkg::SET_FOLLOW && !light_done_i && !int_reset && !run_change) |=>
    $stable(irq_active_o)
  ) else $error("change without run");
  prox_step_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (setting > ipf_pkg::SET_FOLLOW && prox_done_i && prox_judge_i != irq_active_o &&
    !run_change) |=> u_run.cnt != ipf_pkg::CNT_ZERO
  ) else $error("proximity strobe not counted");
  count_clear_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (setting > ipf_pkg::SET_FOLLOW && prox_done_i && prox_judge_i == irq_active_o) |=>
    u_run.cnt == ipf_pkg::CNT_ZERO
  ) else $error("counter not cleared");
  break_run_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (setting > ipf_pkg::SET_FOLLOW && prox_done_i && prox_judge_i != irq_active_o &&
    prox_judge_i != u_run.last_judge) |=> u_run.cnt == ipf_pkg::CNT_ONE
  ) else $error("run not restarted");
  light_only_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (light_done_i && !prox_done_i) |=> $stable(u_run.cnt)
  ) else $error("light counted");
  light_direct_a: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (setting > ipf_pkg::SET_FOLLOW && light_done_i && !run_change && !int_reset) |=>
    irq_active_o == $past(light_judge_i)
  ) else $error("light judgement not applied");
endmodule : ipf_filter

// *** bench/ipf_meas_model.sv ***
// measurement engine model feeding done strobes and judgements
module ipf_meas_model (
  // strobe request
  input wire logic go_i,
  input wire logic prox_i,
  input wire logic judge_i,
  // results
  output logic prox_done_o,
  output logic prox_judge_o,
  output logic light_done_o,
  output logic light_judge_o
);
  // judgement only valid with its strobe, so it flips otherwise
  assign prox_done_o = go_i & prox_i;
  assign light_done_o = go_i & ~prox_i;
  assign prox_judge_o = prox_done_o ? judge_i : ~judge_i;
  assign light_judge_o = light_done_o ? judge_i : ~judge_i;
endmodule : ipf_meas_model

// *** bench/interrupt_persistence_filter_test.sv ***
// self-checking bench for the persistence filter
module interrupt_persistence_filter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 0, rst_i = 1, reg_wr = 0, go = 0, prox = 0, judge = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic pd, pj, ld, lj, irq;
  int fails = 0, num_checks = 0;
  ipf_filter u_ipf_filter (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .prox_done_i(pd),
    .prox_judge_i(pj), .light_done_i(ld), .light_judge_i(lj), .irq_active_o(irq));
  ipf_meas_model u_ipf_meas_model (.go_i(go), .prox_i(prox), .judge_i(judge),
    .prox_done_o(pd), .prox_judge_o(pj), .light_done_o(ld), .light_judge_o(lj));
  // 25 mhz clock
  initial begin
    forever #20 core_clk_i = ~core_clk_i;
  end
  // one compare for byte-wide read data; irq has its own
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // interrupt status compare
  task automatic chk_irq(input logic e);
    num_checks++;
    if (irq !== e) begin
      fails++;
      $display("wrong value irq expected %b seen %b", e, irq);
    end
  endtask : chk_irq
  // single-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk_i);
    reg_wr <= 1'b0;
  endtask : wr
  // read data is registered, one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    addr <= a;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("rdata", e, rdata);
  endtask : rd
  // one measurement, then the status a cycle later
  task automatic ms(input logic p, input logic j, input logic e);
    @(posedge core_clk_i);
    prox <= p;
    judge <= j;
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    @(negedge core_clk_i);
    chk_irq(e);
  endtask : ms
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(8'h43, 8'h01);
    chk_irq(1'b0);
    wr(ipf_pkg::REG_FILTER_SETTING, 8'hf2);
    rd(8'h43, 8'h02);
    rd(8'h44, 8'h00);
    ms(1'b1, 1'b1, 1'b0);
    ms(1'b1, 1'b1, 1'b1);
    ms(1'b1, 1'b0, 1'b1);
    ms(1'b1, 1'b1, 1'b1);
    ms(1'b1, 1'b0, 1'b1);
    ms(1'b1, 1'b0, 1'b0);
    wr(ipf_pkg::REG_FILTER_SETTING, 8'h01);
    ms(1'b1, 1'b1, 1'b1);
    ms(1'b0, 1'b0, 1'b0);
    wr(ipf_pkg::REG_FILTER_SETTING, 8'h03);
    ms(1'b0, 1'b1, 1'b1);
    ms(1'b1, 1'b0, 1'b1);
    ms(1'b1, 1'b0, 1'b1);
    ms(1'b1, 1'b0, 1'b0);
    // longest run: fifteen identical judgements
    wr(ipf_pkg::REG_FILTER_SETTING, 8'h0f);
    for (int i = 0; i < 14; i++) begin
      ms(1'b1, 1'b1, 1'b0);
    end
    ms(1'b1, 1'b1, 1'b1);
    wr(ipf_pkg::REG_FILTER_SETTING, 8'h00);
    wr(ipf_pkg::REG_SYSTEM_CONTROL, 8'h40);
    @(negedge core_clk_i);
    chk_irq(1'b0);
    ms(1'b0, 1'b0, 1'b1);
    wr(ipf_pkg::REG_SYSTEM_CONTROL, 8'h40);
    @(negedge core_clk_i);
    chk_irq(1'b0);
    ms(1'b1, 1'b0, 1'b1);
    // second reset in setting 0000 with the interrupt active restores defaults
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(8'h43, 8'h01);
    chk_irq(1'b0);
    summarize();
  end
endmodule : interrupt_persistence_filter_test
